// ### core/simd_enable_fault_gate.sv
/*
  SIMD enable fault gate: decides per issued SIMD instruction whether it
  executes or faults, holds the control flags, reports leaf 1 feature bits,
  translates register names for a debugger, and raises an interrupt on
  fault events.
  Assumes a 100 MHz clock, Avalon-MM master with waitrequest, and an issue
  port driven by core logic on the same clock.
*/
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module simd_enable_fault_gate
  import simd_gate_pkg::*;
#(
  parameter logic [31:0] FEAT_D = simd_gate_pkg::FEAT_D_DEFAULT,
  parameter logic [31:0] FEAT_C = simd_gate_pkg::FEAT_C_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [simd_gate_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [simd_gate_pkg::DATA_W-1:0] writedata,
  output logic [simd_gate_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic instrValid,
  input wire simd_gate_pkg::instr_class_e instrClass,
  input wire logic simdFpCondition,
  input wire logic debugTrap,
  output logic resultValid,
  output simd_gate_pkg::outcome_e resultCode,
  output logic debugTrapOut,
  output logic irq
);
  import simd_gate_pkg::*;

  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [31:0] ctrl0_reg;
  logic [31:0] ctrl4_reg;
  logic [2:0] stackTop_reg;
  logic [2:0] mapIndex_reg;
  logic [15:0] tagWord_reg;
  logic [IRQ_W-1:0] irqStatus_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  logic resultValid_reg;
  outcome_e resultCode_reg;
  outcome_e lastOutcome_reg;
  logic [7:0] outcomeCount_reg;
  logic debugTrap_reg;
  logic irq_reg;

  logic accept;
  logic wrAccept;
  logic [31:0] byteMask;
  logic [31:0] ctrl4_next;
  logic extSaveFlag;
  logic handlerFlag;
  logic emulationFlag;
  logic taskSwitchedFlag;
  logic featurePresent;
  logic needsExtSave;
  outcome_e outcome_next;
  logic gpEvent;
  logic [IRQ_W-1:0] irqEvents;
  logic [IRQ_W-1:0] irqClear;
  logic [31:0] readValue;
  logic [2:0] stackRelPhys;
  logic [2:0] packedIntPhys;
  logic [2:0] packedIntStackRel;
  logic [1:0] tagOfPhys;

  // bus handshake: answer one cycle after the request is seen
  assign accept = (read | write) & ~waitrequest_reg;
  assign wrAccept = write & ~waitrequest_reg;
  assign byteMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      waitrequest_reg <= 1'b1;
    else
      waitrequest_reg <= ~((read | write) & waitrequest_reg);
  end

  assign extSaveFlag = ctrl4_reg[OS_EXT_SAVE_BIT];
  assign handlerFlag = ctrl4_reg[OS_SIMD_FP_HANDLER_BIT];
  assign emulationFlag = ctrl0_reg[FPU_EMULATION_BIT];
  assign taskSwitchedFlag = ctrl0_reg[TASK_SWITCHED_BIT];

  // control 4 write; bits other than the two flags read as zero
  always_comb
  begin
    ctrl4_next = ctrl4_reg;
    gpEvent = 1'b0;
    if (wrAccept && address == CTRL4_OFS)
    begin
      ctrl4_next = (ctrl4_reg & ~byteMask) | (writedata & byteMask);
      ctrl4_next = ctrl4_next & ((32'h1 << OS_EXT_SAVE_BIT)
                                 | (32'h1 << OS_SIMD_FP_HANDLER_BIT));
      if (!FEAT_D[FEAT_D_EXT_SAVE_BIT] && ctrl4_next[OS_EXT_SAVE_BIT])
      begin
        ctrl4_next[OS_EXT_SAVE_BIT] = ctrl4_reg[OS_EXT_SAVE_BIT];
        gpEvent = byteenable[1];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl4_reg <= CTRL4_RESET;
    else
      ctrl4_reg <= ctrl4_next;
  end

  // flags kept as software writes them; monitor flag has no effect
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl0_reg <= CTRL0_RESET;
    else if (wrAccept && address == CTRL0_OFS)
      ctrl0_reg <= ((ctrl0_reg & ~byteMask) | (writedata & byteMask))
                   & ((32'h1 << MONITOR_COPROC_BIT)
                      | (32'h1 << FPU_EMULATION_BIT)
                      | (32'h1 << TASK_SWITCHED_BIT));
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stackTop_reg <= STACK_TOP_RESET;
      mapIndex_reg <= 3'h0;
      tagWord_reg <= TAG_WORD_RESET;
    end
    else if (wrAccept)
    begin
      if (address == STACK_TOP_OFS && byteenable[0])
        stackTop_reg <= writedata[2:0];
      if (address == MAP_QUERY_OFS && byteenable[0])
        mapIndex_reg <= writedata[2:0];
      // each tag byte lane lands on its own, so a full write keeps both
      if (address == TAG_WORD_OFS && byteenable[0])
        tagWord_reg[7:0] <= writedata[7:0];
      if (address == TAG_WORD_OFS && byteenable[1])
        tagWord_reg[15:8] <= writedata[15:8];
    end
  end

  always_comb
  begin
    featurePresent = 1'b0;
    needsExtSave = 1'b1;
    case (instrClass)
      CLASS_GEN1: featurePresent = FEAT_D[FEAT_D_GEN1_BIT];
      CLASS_GEN2: featurePresent = FEAT_D[FEAT_D_GEN2_BIT];
      CLASS_GEN3: featurePresent = FEAT_C[FEAT_C_GEN3_BIT];
      CLASS_SUPP: featurePresent = FEAT_C[FEAT_C_SUPP_BIT];
      CLASS_GEN4A: featurePresent = FEAT_C[FEAT_C_GEN4A_BIT];
      CLASS_GEN4B: featurePresent = FEAT_C[FEAT_C_GEN4B_BIT];
      CLASS_POPCOUNT:
      begin
        featurePresent = FEAT_C[FEAT_C_POPCOUNT_BIT];
        needsExtSave = 1'b0;
      end
      CLASS_PACKED_INT:
      begin
        featurePresent = 1'b1;
        needsExtSave = 1'b0;
      end
      default: featurePresent = 1'b0;
    endcase
  end

  // population count only checks its feature bit; packed integer skips the
  // extended-save flag but still honours emulation and task-switched
  always_comb
  begin
    outcome_next = OUT_EXECUTE;
    if ((needsExtSave && !extSaveFlag) || !featurePresent)
      outcome_next = OUT_INVALID_OPCODE;
    else if (emulationFlag && instrClass != CLASS_POPCOUNT)
      outcome_next = OUT_INVALID_OPCODE;
    else if (taskSwitchedFlag && instrClass != CLASS_POPCOUNT)
      outcome_next = OUT_DEVICE_NOT_AVAIL;
    else if (simdFpCondition && instrClass != CLASS_PACKED_INT
             && instrClass != CLASS_POPCOUNT)
      outcome_next = handlerFlag ? OUT_SIMD_FP : OUT_INVALID_OPCODE;
    else
      outcome_next = OUT_EXECUTE;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      resultValid_reg <= 1'b0;
      resultCode_reg <= OUT_EXECUTE;
    end
    else
    begin
      resultValid_reg <= instrValid;
      if (instrValid)
        resultCode_reg <= outcome_next;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lastOutcome_reg <= OUT_EXECUTE;
      outcomeCount_reg <= 8'h00;
    end
    else if (instrValid)
    begin
      lastOutcome_reg <= outcome_next;
      outcomeCount_reg <= 8'(outcomeCount_reg + 8'h01);
    end
  end

  // trap passes with equal delay for every class
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      debugTrap_reg <= 1'b0;
    else
      debugTrap_reg <= debugTrap;
  end

  always_comb
  begin
    irqEvents = '0;
    irqEvents[IRQ_PROTECT_BIT] = gpEvent;
    if (instrValid)
    begin
      irqEvents[IRQ_INVALID_BIT] = (outcome_next == OUT_INVALID_OPCODE);
      irqEvents[IRQ_UNAVAIL_BIT] = (outcome_next == OUT_DEVICE_NOT_AVAIL);
      irqEvents[IRQ_SIMDFP_BIT] = (outcome_next == OUT_SIMD_FP);
      irqEvents[IRQ_EXEC_BIT] = (outcome_next == OUT_EXECUTE);
    end
  end

  assign irqClear = (wrAccept && address == IRQ_STATUS_OFS && byteenable[0])
                    ? writedata[IRQ_W-1:0] : '0;

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irqStatus_reg <= '0;
    else
      irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqEvents;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irqMask_reg <= IRQ_MASK_RESET;
    else if (wrAccept && address == IRQ_MASK_OFS && byteenable[0])
      irqMask_reg <= writedata[IRQ_W-1:0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(((irqStatus_reg & ~irqClear) | irqEvents) & irqMask_reg);
  end

  fp_reg_map u_map (
    .stackTop(stackTop_reg),
    .index(mapIndex_reg),
    .stackRelPhys(stackRelPhys),
    .packedIntPhys(packedIntPhys),
    .packedIntStackRel(packedIntStackRel)
  );

  // tag indexed by physical register, never by stack top
  assign tagOfPhys = tagWord_reg[{stackRelPhys, 1'b0} +: 2];

  always_comb
  begin
    readValue = 32'h0000_0000;
    case (address)
      FEAT_D_OFS: readValue = FEAT_D & ((32'h1 << FEAT_D_GEN1_BIT)
                                        | (32'h1 << FEAT_D_GEN2_BIT)
                                        | (32'h1 << FEAT_D_EXT_SAVE_BIT));
      FEAT_C_OFS: readValue = FEAT_C & ((32'h1 << FEAT_C_GEN3_BIT)
                                        | (32'h1 << FEAT_C_SUPP_BIT)
                                        | (32'h1 << FEAT_C_GEN4A_BIT)
                                        | (32'h1 << FEAT_C_GEN4B_BIT)
                                        | (32'h1 << FEAT_C_POPCOUNT_BIT));
      CTRL0_OFS: readValue = ctrl0_reg;
      CTRL4_OFS: readValue = ctrl4_reg;
      STACK_TOP_OFS: readValue = {29'h0, stackTop_reg};
      MAP_QUERY_OFS: readValue = {14'h0, tagOfPhys,
                                  1'b0, packedIntStackRel,
                                  1'b0, packedIntPhys,
                                  1'b0, stackRelPhys,
                                  1'b0, mapIndex_reg};
      RESULT_OFS: readValue = {22'h0, outcomeCount_reg, lastOutcome_reg};
      IRQ_STATUS_OFS: readValue = {27'h0, irqStatus_reg};
      IRQ_MASK_OFS: readValue = {27'h0, irqMask_reg};
      TAG_WORD_OFS: readValue = {16'h0, tagWord_reg};
      default: readValue = 32'h0000_0000;
    endcase
  end

  // data captured at the request edge, stands while waitrequest is low
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      readdata_reg <= 32'h0000_0000;
    else if (read && waitrequest_reg)
      readdata_reg <= readValue;
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign resultValid = resultValid_reg;
  assign resultCode = resultCode_reg;
  assign debugTrapOut = debugTrap_reg;
  assign irq = irq_reg;

endmodule
`default_nettype wire

// ### core/simd_gate_pkg.sv
/*
  Shared constants for the SIMD enable fault gate: register byte offsets,
  control and feature bit positions, reset values and the enumerations of
  instruction classes and outcomes.
  Assumes a 32-bit Avalon-MM slave port with word-aligned byte addresses.
*/
package simd_gate_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [5:0] FEAT_D_OFS = 6'h00;
  localparam logic [5:0] FEAT_C_OFS = 6'h04;
  localparam logic [5:0] CTRL0_OFS = 6'h08;
  localparam logic [5:0] CTRL4_OFS = 6'h0C;
  localparam logic [5:0] STACK_TOP_OFS = 6'h10;
  localparam logic [5:0] MAP_QUERY_OFS = 6'h14;
  localparam logic [5:0] RESULT_OFS = 6'h18;
  localparam logic [5:0] IRQ_STATUS_OFS = 6'h1C;
  localparam logic [5:0] IRQ_MASK_OFS = 6'h20;
  localparam logic [5:0] TAG_WORD_OFS = 6'h24;

  // leaf 1 result register D
  localparam int FEAT_D_EXT_SAVE_BIT = 24;
  localparam int FEAT_D_GEN1_BIT = 25;
  localparam int FEAT_D_GEN2_BIT = 26;
  // leaf 1 result register C
  localparam int FEAT_C_GEN3_BIT = 0;
  localparam int FEAT_C_SUPP_BIT = 9;
  localparam int FEAT_C_GEN4A_BIT = 19;
  localparam int FEAT_C_GEN4B_BIT = 20;
  localparam int FEAT_C_POPCOUNT_BIT = 23;

  // control register 0 and 4 bits
  localparam int MONITOR_COPROC_BIT = 1;
  localparam int FPU_EMULATION_BIT = 2;
  localparam int TASK_SWITCHED_BIT = 3;
  localparam int OS_EXT_SAVE_BIT = 9;
  localparam int OS_SIMD_FP_HANDLER_BIT = 10;

  // interrupt status / mask bits
  localparam int IRQ_INVALID_BIT = 0;
  localparam int IRQ_PROTECT_BIT = 1;
  localparam int IRQ_UNAVAIL_BIT = 2;
  localparam int IRQ_SIMDFP_BIT = 3;
  localparam int IRQ_EXEC_BIT = 4;
  localparam int IRQ_W = 5;

  // reset values
  localparam logic [31:0] CTRL0_RESET = 32'h0000_0004;
  localparam logic [31:0] CTRL4_RESET = 32'h0000_0000;
  localparam logic [2:0] STACK_TOP_RESET = 3'h0;
  localparam logic [15:0] TAG_WORD_RESET = 16'hFFFF;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // default feature support: all present
  localparam logic [31:0] FEAT_D_DEFAULT = 32'h0700_0000;
  localparam logic [31:0] FEAT_C_DEFAULT = 32'h0098_0201;

  typedef enum logic [2:0] {
    CLASS_GEN1,
    CLASS_GEN2,
    CLASS_GEN3,
    CLASS_SUPP,
    CLASS_GEN4A,
    CLASS_GEN4B,
    CLASS_POPCOUNT,
    CLASS_PACKED_INT
  } instr_class_e;

  typedef enum logic [1:0] {
    OUT_EXECUTE,
    OUT_INVALID_OPCODE,
    OUT_DEVICE_NOT_AVAIL,
    OUT_SIMD_FP
  } outcome_e;

endpackage

// ### core/fp_reg_map.sv
/*
  Register name translation between stack-relative names, packed integer
  registers and physical floating-point data registers.
  Assumes a 3-bit stack top pointer held by the caller; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module fp_reg_map (
  input wire logic [2:0] stackTop,
  input wire logic [2:0] index,
  output logic [2:0] stackRelPhys,
  output logic [2:0] packedIntPhys,
  output logic [2:0] packedIntStackRel
);

  // stack-relative name adds to top, wrapping at eight
  assign stackRelPhys = 3'(stackTop + index);
  // packed registers are fixed onto physical ones
  assign packedIntPhys = index;
  // stack-relative name under which a packed register is seen
  assign packedIntStackRel = 3'(index - stackTop);

endmodule
`default_nettype wire

// ### bench/simd_enable_fault_gate_chk.sv
/*
  Port checker for the SIMD enable fault gate.
  Assumes it is bound onto every gate instance with its parameters.
*/
`timescale 1ns/1ns
`default_nettype none
module simd_enable_fault_gate_chk
  import simd_gate_pkg::*;
#(
  parameter logic [31:0] FEAT_D = FEAT_D_DEFAULT,
  parameter logic [31:0] FEAT_C = FEAT_C_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic instrValid,
  input wire simd_gate_pkg::instr_class_e instrClass,
  input wire logic simdFpCondition,
  input wire logic debugTrap,
  input wire logic resultValid,
  input wire simd_gate_pkg::outcome_e resultCode,
  input wire logic debugTrapOut,
  input wire logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_ans;
    instrValid |=> resultValid;
  endproperty
  a_ans: assert property (p_ans) else $error("no result");
  property p_quiet;
    !instrValid |=> !resultValid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray result");
  property p_hold;
    !resultValid |-> $stable(resultCode);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved");
  property p_trap;
    1'b1 |=> debugTrapOut == $past(debugTrap);
  endproperty
  a_trap: assert property (p_trap) else $error("trap lost");
  property p_miss;
    instrValid && instrClass == CLASS_GEN4B && !FEAT_C[FEAT_C_GEN4B_BIT]
      |=> resultCode == OUT_INVALID_OPCODE;
  endproperty
  a_miss: assert property (p_miss) else $error("missing ran");
  property p_pop;
    instrValid && instrClass == CLASS_POPCOUNT
      && !FEAT_C[FEAT_C_POPCOUNT_BIT]
      |=> resultCode == OUT_INVALID_OPCODE;
  endproperty
  a_pop: assert property (p_pop) else $error("count ran");
  property p_noext;
    instrValid && instrClass < CLASS_POPCOUNT
      && !FEAT_D[FEAT_D_EXT_SAVE_BIT]
      |=> resultCode == OUT_INVALID_OPCODE;
  endproperty
  a_noext: assert property (p_noext) else $error("no save ran");
  property p_xm;
    instrValid && !simdFpCondition |=> resultCode != OUT_SIMD_FP;
  endproperty
  a_xm: assert property (p_xm) else $error("fp fault");
  c_issue: cover property (instrValid);
  c_irq: cover property ($rose(irq));
  c_fp: cover property (resultValid && resultCode == OUT_SIMD_FP);
  c_nm: cover property (resultValid && resultCode == OUT_DEVICE_NOT_AVAIL);
endmodule
bind simd_enable_fault_gate simd_enable_fault_gate_chk #(
  .FEAT_D(FEAT_D), .FEAT_C(FEAT_C)
) chk (
  .clk(clk), .rstn(rstn), .instrValid(instrValid),
  .instrClass(instrClass), .simdFpCondition(simdFpCondition),
  .debugTrap(debugTrap), .resultValid(resultValid),
  .resultCode(resultCode), .debugTrapOut(debugTrapOut), .irq(irq)
);
`default_nettype wire

// ### bench/simd_enable_fault_gate_bench.sv
/*
  Bench for the SIMD enable fault gate: issue table, registers, irq, map.
  Assumes nothing of the gate's wait states; every bus wait is bounded.
*/
`timescale 1ns/1ns
`default_nettype none
module simd_enable_fault_gate_bench;
  import simd_gate_pkg::*;
  // gen4 part two and popcount absent here
  localparam logic [31:0] FC = 32'h0008_0201;
  typedef struct packed {
    instr_class_e cls;
    logic [3:0] c0;
    logic [1:0] c4;
    logic fp;
    outcome_e exp;
  } row_s;
  logic clk, rstn, read, write, instrValid, simdFpCondition, debugTrap;
  logic waitrequest, waitrequest2, resultValid, debugTrapOut, irq, irq2;
  logic [5:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, readdata2, q, q2;
  instr_class_e instrClass;
  outcome_e resultCode, resultCode2;
  int fails, nChecks, p;
  logic [5:0] ra [7] = '{FEAT_D_OFS, FEAT_C_OFS, CTRL0_OFS, CTRL4_OFS,
    IRQ_STATUS_OFS, IRQ_MASK_OFS, TAG_WORD_OFS};
  logic [31:0] rv [7] = '{FEAT_D_DEFAULT, FC, CTRL0_RESET, CTRL4_RESET,
    32'h0, 32'h0, 32'h0000_FFFF};
  row_s rows [13] = '{
    '{CLASS_GEN1, 4'h2, 2'h3, 1'b0, OUT_EXECUTE},
    '{CLASS_GEN1, 4'h2, 2'h2, 1'b0, OUT_INVALID_OPCODE},
    '{CLASS_GEN4B, 4'h2, 2'h3, 1'b0, OUT_INVALID_OPCODE},
    '{CLASS_GEN2, 4'h6, 2'h3, 1'b0, OUT_INVALID_OPCODE},
    '{CLASS_GEN3, 4'hA, 2'h3, 1'b0, OUT_DEVICE_NOT_AVAIL},
    '{CLASS_SUPP, 4'hE, 2'h3, 1'b0, OUT_INVALID_OPCODE},
    '{CLASS_GEN4A, 4'h2, 2'h3, 1'b1, OUT_SIMD_FP},
    '{CLASS_GEN2, 4'h2, 2'h1, 1'b1, OUT_INVALID_OPCODE},
    '{CLASS_POPCOUNT, 4'h2, 2'h0, 1'b0, OUT_INVALID_OPCODE},
    '{CLASS_PACKED_INT, 4'hA, 2'h0, 1'b0, OUT_DEVICE_NOT_AVAIL},
    '{CLASS_PACKED_INT, 4'h6, 2'h0, 1'b0, OUT_INVALID_OPCODE},
    '{CLASS_SUPP, 4'h8, 2'h0, 1'b0, OUT_INVALID_OPCODE},
    '{CLASS_PACKED_INT, 4'h2, 2'h0, 1'b1, OUT_EXECUTE}};
  simd_enable_fault_gate #(.FEAT_C(FC)) uut (
    .clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .instrValid(instrValid), .instrClass(instrClass),
    .simdFpCondition(simdFpCondition), .debugTrap(debugTrap),
    .resultValid(resultValid), .resultCode(resultCode),
    .debugTrapOut(debugTrapOut), .irq(irq));
  // twin with every feature but the save one, fed the same bus
  simd_enable_fault_gate #(.FEAT_D(32'h0600_0000)) uut2 (
    .clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata2), .waitrequest(waitrequest2),
    .instrValid(instrValid), .instrClass(instrClass),
    .simdFpCondition(simdFpCondition), .debugTrap(debugTrap),
    .resultValid(), .resultCode(resultCode2), .debugTrapOut(),
    .irq(irq2));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d fails %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [31:0] d);
    int n;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    n = 0;
    // outputs read here still hold their values from before this edge
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    q = readdata;
    q2 = readdata2;
    read <= 1'b0;
    write <= 1'b0;
    if (n < 20)
      @(posedge clk);
    else
    begin
      fails++;
      close_out();
    end
  endtask
  task automatic issue(input instr_class_e c, input logic f);
    instrClass <= c;
    simdFpCondition <= f;
    instrValid <= 1'b1;
    @(posedge clk);
    instrValid <= 1'b0;
    @(negedge clk);
    chk(resultValid, 1'b1);
    chk(debugTrapOut, debugTrap);
    @(posedge clk);
  endtask
  initial
  begin
    fails = 0;
    nChecks = 0;
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    byteenable = 4'hF;
    writedata = 32'h0;
    instrValid = 1'b0;
    instrClass = CLASS_GEN1;
    simdFpCondition = 1'b0;
    debugTrap = 1'b0;
    repeat (3) @(posedge clk);
    chk(waitrequest, 1'b1);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      bus(1'b1, CTRL0_OFS, {28'h0, rows[i].c0});
      bus(1'b1, CTRL4_OFS, {21'h0, rows[i].c4, 9'h0});
      debugTrap <= i[0];
      issue(rows[i].cls, rows[i].fp);
      chk(resultCode, rows[i].exp);
    end
    $display("issue table done");
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
    // feature words are read only
    for (int j = 0; j < 2; j++)
    begin
      bus(1'b1, ra[j], 32'h0);
      bus(1'b0, ra[j], 32'h0);
      chk(q, rv[j]);
    end
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
    bus(1'b0, 6'h3C, 32'h0);
    chk(q, 32'h0);
    $display("register test done");
    bus(1'b1, CTRL4_OFS, 32'h0000_0600);
    bus(1'b0, CTRL4_OFS, 32'h0);
    chk(q, 32'h0000_0600);
    chk(q2, 32'h0000_0400);
    bus(1'b0, IRQ_STATUS_OFS, 32'h0);
    chk(q2[IRQ_PROTECT_BIT], 1'b1);
    $display("protection test done");
    bus(1'b1, IRQ_MASK_OFS, 32'h1);
    bus(1'b1, CTRL4_OFS, 32'h0);
    chk(irq, 1'b0);
    issue(CLASS_GEN1, 1'b0);
    @(negedge clk);
    chk(irq, 1'b1);
    @(posedge clk);
    bus(1'b1, IRQ_STATUS_OFS, 32'h1);
    chk(irq, 1'b0);
    bus(1'b1, IRQ_MASK_OFS, 32'h0);
    issue(CLASS_GEN2, 1'b0);
    @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
    bus(1'b0, IRQ_STATUS_OFS, 32'h0);
    chk(q[IRQ_INVALID_BIT], 1'b1);
    $display("interrupt test done");
    // emulation still set from reset: counting ignores it and the save flag
    issue(CLASS_POPCOUNT, 1'b0);
    chk(resultCode2, OUT_EXECUTE);
    chk(resultCode, OUT_INVALID_OPCODE);
    $display("count test done");
    // top of 7 makes most names wrap
    bus(1'b1, STACK_TOP_OFS, 32'h7);
    bus(1'b1, TAG_WORD_OFS, 32'h0000_E41B);
    for (int n = 0; n < 8; n++)
    begin
      bus(1'b1, MAP_QUERY_OFS, n);
      bus(1'b0, MAP_QUERY_OFS, 32'h0);
      p = (n + 7) % 8;
      chk(q, n | p << 4 | n << 8 | ((n + 1) % 8) << 12
        | ((32'hE41B >> 2 * p) & 3) << 16);
    end
    $display("map test done");
    close_out();
  end
endmodule
`default_nettype wire
